// >>> epc_defs.svh
`ifndef EPC_DEFS_SVH
`define EPC_DEFS_SVH
// Register byte offsets
`define EPC_OFF_LATCH    8'h00
`define EPC_OFF_DIR      8'h04
`define EPC_OFF_PULL     8'h08
`define EPC_OFF_SLEW     8'h0C
`define EPC_OFF_DRIVE    8'h10
`define EPC_OFF_EDGE     8'h14
`define EPC_OFF_PSEL     8'h18
`define EPC_OFF_PIN      8'h1C
// Reset values
`define EPC_RST_BYTE     8'h00
// AXI responses
`define EPC_RESP_OKAY    2'b00
`define EPC_RESP_SLVERR  2'b10
// Register index field of the address
`define EPC_IDX_MSB      4
`define EPC_IDX_LSB      2
`endif

// >>> epc_pins.sv
`timescale 1ns/1ps
module epc_pins
  import epc_pkg::*;
(
  // Clock
  input  wire logic       clk_i,
  // Pads and outside drive
  input  wire epc_pad_t   pad_i,
  input  wire logic [7:0] ext_val_i,
  input  wire logic [7:0] ext_en_i,
  // Pin levels seen by the port
  output logic [7:0]      pin_o
);
  logic [7:0] float_q = 8'h00;

  // Undriven pins with no pull wander every cycle
  always @(posedge clk_i)
  begin
    float_q <= ~float_q;
  end

  // Pulls only decide pins that nobody drives
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      pin_o[i] = pad_i.oe[i] ? pad_i.out[i] : ext_en_i[i] ? ext_val_i[i] :
                 pad_i.pull_up[i] ? 1'b1 :
                 pad_i.pull_dn[i] ? 1'b0 : float_q[i];
    end
  end
endmodule

// >>> epc_pkg.sv
package epc_pkg;
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] pull_up;
    logic [7:0] pull_dn;
    logic [7:0] slew;
    logic [7:0] drive_hi;
  } epc_pad_t;

  typedef enum logic [1:0] {
    EPC_IDLE  = 2'b00,
    EPC_RESP  = 2'b01
  } epc_bus_t;

  typedef struct packed {
    logic [7:0] latch;
    logic [7:0] dir;
    logic [7:0] pull;
    logic [7:0] slew;
    logic [7:0] drive;
    logic [7:0] edge_pol;
    logic [7:0] psel;
    logic [7:0] sync1;
    logic [7:0] sync2;
    logic [7:0] sync3;
    logic [7:0] pin_level;
    logic       aw_held;
    logic [2:0] aw_idx;
    logic       aw_bad;
    logic       w_held;
    logic [7:0] w_byte;
    logic       w_lane;
    logic       bvalid;
    logic [1:0] bresp;
    logic       rvalid;
    logic [7:0] rbyte;
    logic [1:0] rresp;
    epc_pad_t   pad;
  } epc_state_t;
endpackage

// >>> epc_port.sv
// The register addresses and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
`include "epc_defs.svh"
// How it works
// - An input pin reads back as its synchronised pin level.
// - An output pin reads back as the last value software wrote.
// - A data write loads all eight latch bits whatever the direction.
// - An output pin drives its latch bit unless a peripheral owns the buffer.
// - Reset clears the latch and leaves all pins undriven with no pulls.
// - Direction 0 disables the driver and reads the pin, 1 the reverse; a peripheral owning the buffer sets its own driver enable.
// - A pull-enable bit of 1 switches on that pin's pull device.
// - An output pin never has its pull device on.
// - A pull-down is used only on a pin selected for interrupt use.
// - A slew bit of 1 limits edge rate, only on an output pin.
// - A drive bit of 1 selects high drive, only on an output pin.
// - With the pull on, edge polarity 1 on an interrupt-selected pin gives pull-down, any other pin gets pull-up.
// - With a peripheral owning the buffer, direction still picks reads.
module epc_port
  import epc_pkg::*;
#(
  parameter int PINS = 8
)(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // AXI4-Lite write address and data
  input  wire logic [7:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  // AXI4-Lite read
  input  wire logic [7:0]  s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  // Shared peripheral override of the output buffer
  input  wire logic [7:0]  periph_en_i,
  input  wire logic [7:0]  periph_out_i,
  input  wire logic [7:0]  periph_oe_i,
  // Pads
  input  wire logic [7:0]  pad_in_i,
  output logic [7:0]       pad_out_o,
  output logic [7:0]       pad_oe_o,
  output logic [7:0]       pad_pull_up_o,
  output logic [7:0]       pad_pull_dn_o,
  output logic [7:0]       pad_slew_o,
  output logic [7:0]       pad_drive_hi_o
);

  initial
  begin
    if (PINS != 8)
    begin
      $error("epc_port serves exactly eight pins");
    end
  end

  // ==========================================================
  // Helpers
  // ==========================================================
  function automatic logic epc_mapped(input logic [2:0] idx);
    epc_mapped = (idx <= 3'(`EPC_OFF_PIN >> `EPC_IDX_LSB));
  endfunction

  function automatic logic [2:0] epc_index(input logic [7:0] addr);
    epc_index = addr[`EPC_IDX_MSB:`EPC_IDX_LSB];
  endfunction

  function automatic logic epc_in_range(input logic [7:0] addr);
    epc_in_range = (addr[7:`EPC_IDX_MSB+1] == '0) &&
                   epc_mapped(epc_index(addr));
  endfunction

  epc_state_t st;
  epc_state_t next_st;
  logic [7:0] read_src;
  logic [7:0] out_en;
  logic       do_write;

  // ==========================================================
  // Next state
  // ==========================================================
  always_comb
  begin
    next_st = st;
    // Three-stage pin sampler, change taken when stages 2 and 3 agree
    next_st.sync1 = pad_in_i;
    next_st.sync2 = st.sync1;
    next_st.sync3 = st.sync2;
    for (int i = 0; i < 8; i++)
    begin
      if (st.sync2[i] == st.sync3[i])
      begin
        next_st.pin_level[i] = st.sync3[i];
      end
    end

    // Write channel capture
    if (s_axi_awvalid_i && !st.aw_held)
    begin
      next_st.aw_held = 1'b1;
      next_st.aw_idx  = epc_index(s_axi_awaddr_i);
      next_st.aw_bad  = !epc_in_range(s_axi_awaddr_i);
    end
    if (s_axi_wvalid_i && !st.w_held)
    begin
      next_st.w_held = 1'b1;
      next_st.w_byte = s_axi_wdata_i[7:0];
      next_st.w_lane = s_axi_wstrb_i[0];
    end

    do_write = st.aw_held && st.w_held && !st.bvalid;
    if (do_write)
    begin
      next_st.aw_held = 1'b0;
      next_st.w_held  = 1'b0;
      next_st.bvalid  = 1'b1;
      next_st.bresp   = st.aw_bad ? `EPC_RESP_SLVERR : `EPC_RESP_OKAY;
      if (!st.aw_bad && st.w_lane)
      begin
        unique case ({st.aw_idx, 2'b00})
          5'(`EPC_OFF_LATCH): next_st.latch = st.w_byte;
          5'(`EPC_OFF_DIR):   next_st.dir   = st.w_byte;
          5'(`EPC_OFF_PULL):  next_st.pull  = st.w_byte;
          5'(`EPC_OFF_SLEW):  next_st.slew  = st.w_byte;
          5'(`EPC_OFF_DRIVE): next_st.drive = st.w_byte;
          5'(`EPC_OFF_EDGE):  next_st.edge_pol = st.w_byte;
          5'(`EPC_OFF_PSEL):  next_st.psel  = st.w_byte;
          default:            next_st.latch = next_st.latch;
        endcase
      end
    end
    if (st.bvalid && s_axi_bready_i)
    begin
      next_st.bvalid = 1'b0;
    end

    // Data reads: direction picks latch or pin, even under a peripheral
    read_src = (st.dir & st.latch) | (~st.dir & st.pin_level);
    if (s_axi_arvalid_i && !st.rvalid)
    begin
      next_st.rvalid = 1'b1;
      next_st.rresp  = epc_in_range(s_axi_araddr_i) ?
                       `EPC_RESP_OKAY : `EPC_RESP_SLVERR;
      unique case ({epc_index(s_axi_araddr_i), 2'b00})
        5'(`EPC_OFF_LATCH): next_st.rbyte = read_src;
        5'(`EPC_OFF_DIR):   next_st.rbyte = st.dir;
        5'(`EPC_OFF_PULL):  next_st.rbyte = st.pull;
        5'(`EPC_OFF_SLEW):  next_st.rbyte = st.slew;
        5'(`EPC_OFF_DRIVE): next_st.rbyte = st.drive;
        5'(`EPC_OFF_EDGE):  next_st.rbyte = st.edge_pol;
        5'(`EPC_OFF_PSEL):  next_st.rbyte = st.psel;
        default:            next_st.rbyte = st.pin_level;
      endcase
      if (!epc_in_range(s_axi_araddr_i))
      begin
        next_st.rbyte = `EPC_RST_BYTE;
      end
    end
    if (st.rvalid && s_axi_rready_i)
    begin
      next_st.rvalid = 1'b0;
    end

    // Pad control
    out_en = (periph_en_i & periph_oe_i) | (~periph_en_i & st.dir);
    next_st.pad.oe  = out_en;
    next_st.pad.out = (periph_en_i & periph_out_i) |
                      (~periph_en_i & st.latch);
    for (int i = 0; i < 8; i++)
    begin
      // Pull only on inputs; pull-down only for interrupt pins
      next_st.pad.pull_dn[i] = st.pull[i] && !out_en[i] &&
                               st.edge_pol[i] && st.psel[i];
      next_st.pad.pull_up[i] = st.pull[i] && !out_en[i] &&
                               !(st.edge_pol[i] && st.psel[i]);
    end
    next_st.pad.slew     = st.slew & out_en;
    next_st.pad.drive_hi = st.drive & out_en;
  end

  // ==========================================================
  // State register
  // ==========================================================
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  assign s_axi_awready_o = !st.aw_held;
  assign s_axi_wready_o  = !st.w_held;
  assign s_axi_bvalid_o  = st.bvalid;
  assign s_axi_bresp_o   = st.bresp;
  assign s_axi_arready_o = !st.rvalid;
  assign s_axi_rvalid_o  = st.rvalid;
  assign s_axi_rresp_o   = st.rresp;
  assign s_axi_rdata_o   = {24'h00_0000, st.rbyte};
  assign pad_out_o       = st.pad.out;
  assign pad_oe_o        = st.pad.oe;
  assign pad_pull_up_o   = st.pad.pull_up;
  assign pad_pull_dn_o   = st.pad.pull_dn;
  assign pad_slew_o      = st.pad.slew;
  assign pad_drive_hi_o  = st.pad.drive_hi;

  // ==========================================================
  // Checks
  // ==========================================================
  a_pull_not_out: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ((pad_pull_up_o | pad_pull_dn_o) & pad_oe_o) == 8'h00)
    else $error("pull active on a driven pin");

  a_pull_one_way: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (pad_pull_up_o & pad_pull_dn_o) == 8'h00)
    else $error("pull-up and pull-down both on");

  a_dn_needs_sel: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (pad_pull_dn_o & ~($past(st.psel) & $past(st.edge_pol))) == 8'h00)
    else $error("pull-down without interrupt selection");

  a_pull_follows: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ##1 (pad_pull_up_o | pad_pull_dn_o) ==
    ($past(st.pull) & ~$past(out_en)))
    else $error("pull does not follow its enable");

  a_slew_gated: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (pad_slew_o & ~pad_oe_o) == 8'h00)
    else $error("slew set on an input");

  a_drive_gated: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ##1 pad_drive_hi_o == ($past(st.drive) & $past(out_en)))
    else $error("drive select wrong");

  a_latch_write: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (do_write && !st.aw_bad && st.w_lane &&
     st.aw_idx == 3'(`EPC_OFF_LATCH >> `EPC_IDX_LSB))
    |=> st.latch == $past(st.w_byte))
    else $error("latch write lost");

  a_out_drives: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (periph_en_i == 8'h00 && st.dir == 8'hFF) ##1 (periph_en_i == 8'h00)
    |-> pad_out_o == $past(st.latch) && pad_oe_o == 8'hFF)
    else $error("output pins not driving the latch");

  a_read_mux: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (s_axi_arvalid_i && !st.rvalid && s_axi_araddr_i == `EPC_OFF_LATCH)
    |=> s_axi_rdata_o[7:0] ==
    (($past(st.dir) & $past(st.latch)) |
     (~$past(st.dir) & $past(st.pin_level))))
    else $error("data read source wrong");

  a_bresp_once: assert property (
    @(posedge clk_i) disable iff (rst_i)
    do_write |=> s_axi_bvalid_o)
    else $error("write response missing");

  a_oe_follows: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ##1 pad_oe_o == $past(out_en))
    else $error("driver enable does not follow direction");

  a_out_value: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ##1 pad_out_o == $past((periph_en_i & periph_out_i) |
                           (~periph_en_i & st.latch)))
    else $error("driven value wrong");

  a_slew_follows: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ##1 pad_slew_o == ($past(st.slew) & $past(out_en)))
    else $error("slew select wrong");

  a_dn_polarity: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ##1 pad_pull_dn_o ==
    $past(st.pull & ~out_en & st.edge_pol & st.psel))
    else $error("pull-down polarity wrong");

  a_up_polarity: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ##1 pad_pull_up_o ==
    $past(st.pull & ~out_en & ~(st.edge_pol & st.psel)))
    else $error("pull-up polarity wrong");

  a_dir_write: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (do_write && !st.aw_bad && st.w_lane &&
     st.aw_idx == 3'(`EPC_OFF_DIR >> `EPC_IDX_LSB))
    |=> st.dir == $past(st.w_byte))
    else $error("direction write lost");

  a_pull_write: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (do_write && !st.aw_bad && st.w_lane &&
     st.aw_idx == 3'(`EPC_OFF_PULL >> `EPC_IDX_LSB))
    |=> st.pull == $past(st.w_byte))
    else $error("pull enable write lost");

  a_edge_write: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (do_write && !st.aw_bad && st.w_lane &&
     st.aw_idx == 3'(`EPC_OFF_EDGE >> `EPC_IDX_LSB))
    |=> st.edge_pol == $past(st.w_byte))
    else $error("edge polarity write lost");

  a_strobe_off: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (do_write && !st.w_lane) |=> st.latch == $past(st.latch))
    else $error("write without lane strobe changed the latch");

  a_bad_resp: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (do_write && st.aw_bad) |=> s_axi_bresp_o == `EPC_RESP_SLVERR)
    else $error("unmapped write not refused");

  a_pin_sync: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (st.sync2 == st.sync3) |=> st.pin_level == $past(st.sync3))
    else $error("settled pin level not taken");

  a_rresp_bad: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (s_axi_arvalid_i && s_axi_arready_o &&
     s_axi_araddr_i[7:`EPC_IDX_MSB+1] != '0)
    |=> s_axi_rresp_o == `EPC_RESP_SLVERR && s_axi_rdata_o == '0)
    else $error("unmapped read not refused");

  a_drive_input: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (pad_drive_hi_o & ~pad_oe_o) == 8'h00)
    else $error("high drive set on an input");

  a_read_pin: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i == `EPC_OFF_PIN)
    |=> s_axi_rdata_o[7:0] == $past(st.pin_level))
    else $error("pin level read wrong");

endmodule

// >>> epc_port_test.sv
`timescale 1ns/1ps
`include "epc_defs.svh"
module epc_port_test
  import epc_pkg::*;
;
  logic        clk, rst, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [7:0]  awaddr, araddr, pen, pout, poe, ext_val, ext_en, pin;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  wire epc_pad_t pad;
  int          n_errors, total_checks, cycles;

  epc_port dut (.clk_i(clk), .rst_i(rst), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
    .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .periph_en_i(pen), .periph_out_i(pout),
    .periph_oe_i(poe), .pad_in_i(pin), .pad_out_o(pad.out),
    .pad_oe_o(pad.oe), .pad_pull_up_o(pad.pull_up),
    .pad_pull_dn_o(pad.pull_dn), .pad_slew_o(pad.slew),
    .pad_drive_hi_o(pad.drive_hi));

  epc_pins pins (.clk_i(clk), .pad_i(pad), .ext_val_i(ext_val),
    .ext_en_i(ext_en), .pin_o(pin));

  // ==========================
  // Clock and timeout
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      n_errors++;
      results();
    end
  end

  // ==========================
  // Checks and bus tasks
  task results;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task chk(input logic [47:0] g, input logic [47:0] e);
    total_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task padchk(input logic [47:0] e);
    repeat (2) @(posedge clk);
    chk({pad.oe, pad.out & pad.oe, pad.pull_up, pad.pull_dn, pad.slew,
         pad.drive_hi}, e);
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s,
          input logic [1:0] er);
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever
    begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    chk(48'(bresp), 48'(er));
    @(posedge clk);
  endtask

  task rd(input logic [7:0] a, input logic [7:0] ed, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever
    begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    chk({rresp, rdata}, {er, 24'h00_0000, ed});
    @(posedge clk);
  endtask

  task reset_dut;
    rst <= 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    for (int a = 0; a < 32; a += 4)
      rd(8'(a), 8'h00, `EPC_RESP_OKAY);
    padchk(48'h0000_0000_0000);
  endtask

  // ==========================
  // Main sequence
  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, pen, pout, poe, ext_val} = '0;
    {wdata, wstrb, n_errors, total_checks, cycles} = '0;
    ext_en = 8'hFF;
    rst = 1'b1;
    @(posedge clk);
    reset_dut();
    ext_val <= 8'h3C;
    wr(`EPC_OFF_LATCH, 8'hA5, 4'hF, `EPC_RESP_OKAY);
    repeat (6) @(posedge clk);
    rd(`EPC_OFF_LATCH, 8'h3C, `EPC_RESP_OKAY);
    padchk(48'h0000_0000_0000);
    ext_en <= 8'h0F;
    wr(`EPC_OFF_DIR, 8'hF0, 4'hF, `EPC_RESP_OKAY);
    repeat (6) @(posedge clk);
    rd(`EPC_OFF_LATCH, 8'hAC, `EPC_RESP_OKAY);
    padchk(48'hF0A0_0000_0000);
    ext_en <= 8'h00;
    wr(`EPC_OFF_PULL, 8'hFF, 4'hF, `EPC_RESP_OKAY);
    padchk(48'hF0A0_0F00_0000);
    wr(`EPC_OFF_EDGE, 8'h13, 4'hF, `EPC_RESP_OKAY);
    padchk(48'hF0A0_0F00_0000);
    wr(`EPC_OFF_PSEL, 8'h11, 4'hF, `EPC_RESP_OKAY);
    padchk(48'hF0A0_0E01_0000);
    repeat (6) @(posedge clk);
    rd(`EPC_OFF_LATCH, 8'hAE, `EPC_RESP_OKAY);
    wr(`EPC_OFF_SLEW, 8'hFF, 4'hF, `EPC_RESP_OKAY);
    wr(`EPC_OFF_DRIVE, 8'h3C, 4'hF, `EPC_RESP_OKAY);
    padchk(48'hF0A0_0E01_F030);
    pen <= 8'h81;
    poe <= 8'h81;
    pout <= 8'h01;
    padchk(48'hF121_0E00_F130);
    repeat (6) @(posedge clk);
    rd(`EPC_OFF_LATCH, 8'hAF, `EPC_RESP_OKAY);
    {pen, poe, pout} <= '0;
    wr(`EPC_OFF_LATCH, 8'hFF, 4'h0, `EPC_RESP_OKAY);
    repeat (6) @(posedge clk);
    rd(`EPC_OFF_LATCH, 8'hAE, `EPC_RESP_OKAY);
    wr(`EPC_OFF_LATCH, 8'h5A, 4'hF, `EPC_RESP_OKAY);
    padchk(48'hF050_0E01_F030);
    repeat (6) @(posedge clk);
    rd(`EPC_OFF_LATCH, 8'h5E, `EPC_RESP_OKAY);
    wr(`EPC_OFF_PIN, 8'h00, 4'hF, `EPC_RESP_OKAY);
    rd(`EPC_OFF_PIN, 8'h5E, `EPC_RESP_OKAY);
    wr(8'h20, 8'h00, 4'hF, `EPC_RESP_SLVERR);
    rd(8'h20, 8'h00, `EPC_RESP_SLVERR);
    wr(`EPC_OFF_DIR, 8'hFF, 4'hF, `EPC_RESP_OKAY);
    padchk(48'hFF5A_0000_FF3C);
    rd(`EPC_OFF_LATCH, 8'h5A, `EPC_RESP_OKAY);
    ext_en <= 8'hFF;
    ext_val <= 8'h00;
    reset_dut();
    results();
  end
endmodule
